// *** src/fieldbus_io_pkg.sv ***
// Constants, field layouts and carrier types of the fieldbus I/O data mapper.
// Assumes one 250 MHz clock and an asynchronous active-low reset.
// Contract
// - Read slots 8 to 10 hold a register address; values 0 to 2 disable.
// - Node address 0 or above 125 raises the node error indicator.
// - Node address and format take effect only after power-up latching.
// - Writing an Enter-variant format over the fieldbus auto-executes Enter.
// - Frame length is 32, 12 or 6 bytes as the master chooses.
// - Conventional formats are used only with the conventional selection.
// - Run/stop and frequency reference reach the drive within 2 ms.
// - Message data is edited before reaching the drive; master handshakes.
// - Frame splits into high-speed and message regions per frame length.
// - Basic output: command 0-1, frequency 2-3, torque 4-5, high first.
// - Basic input: status 0-1, speed 2-3, current 4-5, high first.
// - Torque field applies only when torque reference enable is 1.
// - In V/f or open-loop PM, speed field carries output frequency.
// - Message region gives access to all drive parameters and data.
// - Run accepted only if run source is 3; reference if source is 3.
// - Clear Mode zeroes outputs (setting 0) or holds them (setting 1).
// - Format codes: 0 PPO, 1 conv, 2 bit0, 3/4/5 Enter variants.
package fieldbus_io_pkg;

	localparam logic [15:0] ADDR_PW8_READ   = 16'h0791;
	localparam logic [15:0] ADDR_PW9_READ   = 16'h0792;
	localparam logic [15:0] ADDR_PW10_READ  = 16'h0793;
	localparam logic [15:0] RST_READ_MAP    = 16'h0000;
	localparam logic [15:0] SLOT_DIS_MAX    = 16'h0002;

	localparam logic [6:0]  NODE_ADDR_MAX   = 7'h7D;

	localparam logic [2:0]  FMT_PPO         = 3'h0;
	localparam logic [2:0]  FMT_CONV        = 3'h1;
	localparam logic [2:0]  FMT_PPO_BIT0    = 3'h2;
	localparam logic [2:0]  FMT_PPO_ENTER   = 3'h3;
	localparam logic [2:0]  FMT_CONV_ENTER  = 3'h4;
	localparam logic [2:0]  FMT_BIT0_ENTER  = 3'h5;

	localparam logic [1:0]  SRC_FIELDBUS    = 2'h3;

	localparam logic [5:0]  LEN_BASIC       = 6'h06;
	localparam logic [5:0]  LEN_EXT1        = 6'h20;
	localparam logic [5:0]  LEN_EXT2        = 6'h0C;
	localparam logic [4:0]  HS_LAST_BASIC   = 5'h05;
	localparam logic [4:0]  HS_LAST_EXT1    = 5'h0F;
	localparam logic [4:0]  HS_LAST_EXT2    = 5'h03;
	localparam logic [4:0]  MB_BASE_EXT1    = 5'h10;
	localparam logic [4:0]  MB_BASE_EXT2    = 5'h04;

	localparam logic [4:0]  BYTE_CMD        = 5'h00;
	localparam logic [4:0]  BYTE_FREQ       = 5'h02;
	localparam logic [4:0]  BYTE_TORQUE     = 5'h04;

	localparam int          CLK_MHZ         = 250;
	localparam int          FWD_LIMIT_US    = 2000;
	localparam int          FWD_LIMIT_CYC   = FWD_LIMIT_US * CLK_MHZ;

	typedef enum logic [1:0] {
		FRAME_BASIC,
		FRAME_EXT1,
		FRAME_EXT2
	} frame_len_t;

	typedef struct packed {
		logic [15:0] op_cmd;
		logic [15:0] freq_ref;
		logic [15:0] torque_ref;
	} drive_cmd_t;

	typedef struct packed {
		logic [15:0] status;
		logic [15:0] speed;
		logic [15:0] out_freq;
		logic [15:0] current;
	} drive_stat_t;

endpackage

// *** src/fieldbus_io_data_mapper.sv ***
// Fieldbus cyclic I/O data mapper between the fieldbus link and the drive.
// Assumes frame bytes arrive synchronous to mclk, one per rx_valid cycle.
`timescale 1ns/10ps

module fieldbus_io_data_mapper #(
	parameter int MB_BYTES = 16
) (
	input  wire logic                         mclk,
	input  wire logic                         arst_n,
	input  wire logic [6:0]                   node_address_setting,
	input  wire logic [2:0]                   data_format_select,
	input  wire logic                         clear_mode_action,
	input  wire logic                         torque_ref_enable,
	input  wire logic [1:0]                   run_cmd_source,
	input  wire logic [1:0]                   freq_ref_source,
	input  wire logic                         vf_control,
	input  wire logic                         open_loop_pm_control,
	input  wire logic                         fmt_param_wr,
	input  wire logic [2:0]                   fmt_param_val,
	input  wire logic                         par_wr,
	input  wire logic                         par_rd,
	input  wire logic [15:0]                  par_addr,
	input  wire logic [15:0]                  par_wdata,
	input  wire logic [47:0]                  slot_data,
	input  wire fieldbus_io_pkg::frame_len_t  frame_len_sel,
	input  wire logic                         rx_valid,
	input  wire logic                         rx_sof,
	input  wire logic [7:0]                   rx_byte,
	input  wire logic                         clear_cmd,
	input  wire logic                         tx_req,
	input  wire logic [4:0]                   tx_index,
	input  wire fieldbus_io_pkg::drive_stat_t drive_stat,
	input  wire logic [8*MB_BYTES-1:0]        mb_reply,
	output logic [15:0]                       par_rdata,
	output logic                              par_ack,
	output logic [47:0]                       slot_addr,
	output logic [2:0]                        slot_enabled,
	output logic [47:0]                       slot_word,
	output logic                              node_err,
	output logic                              cfg_conventional,
	output logic                              auto_enter,
	output fieldbus_io_pkg::drive_cmd_t       drive_cmd,
	output logic                              mb_valid,
	output logic [4:0]                        mb_index,
	output logic [7:0]                        mb_byte,
	output logic                              tx_ack,
	output logic [7:0]                        tx_byte
);

	// Message region width is fixed by the largest frame
	if (MB_BYTES != 16) begin
		$error("MB_BYTES must be 16");
	end

	logic [15:0]                 read_map [3];
	logic                        cfg_loaded;
	logic [6:0]                  cfg_node;
	logic [2:0]                  cfg_fmt;
	fieldbus_io_pkg::frame_len_t act_len;
	logic [4:0]                  idx;
	logic                        idx_over;
	logic [15:0]                 op_sh;
	logic [15:0]                 freq_sh;
	logic [15:0]                 torque_sh;
	logic                        commit_pend;
	logic [5:0]                  cur_len;
	logic [4:0]                  cur_idx;
	logic                        take;
	logic [15:0]                 spd;
	logic [4:0]                  mb_off;

	function automatic logic [5:0] len_of(fieldbus_io_pkg::frame_len_t l);
		case (l)
			fieldbus_io_pkg::FRAME_EXT1: len_of = fieldbus_io_pkg::LEN_EXT1;
			fieldbus_io_pkg::FRAME_EXT2: len_of = fieldbus_io_pkg::LEN_EXT2;
			default:                     len_of = fieldbus_io_pkg::LEN_BASIC;
		endcase
	endfunction

	function automatic logic [4:0] hs_last(fieldbus_io_pkg::frame_len_t l);
		case (l)
			fieldbus_io_pkg::FRAME_EXT1: hs_last = fieldbus_io_pkg::HS_LAST_EXT1;
			fieldbus_io_pkg::FRAME_EXT2: hs_last = fieldbus_io_pkg::HS_LAST_EXT2;
			default:                     hs_last = fieldbus_io_pkg::HS_LAST_BASIC;
		endcase
	endfunction

	function automatic logic [7:0] word_byte(logic [15:0] w, logic lo);
		word_byte = lo ? w[7:0] : w[15:8];
	endfunction

	// Parameter port for the read slot map
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 3; i++)
				read_map[i] <= fieldbus_io_pkg::RST_READ_MAP;
			par_rdata <= 16'h0000;
			par_ack   <= 1'b0;
		end else begin
			par_ack <= par_wr | par_rd;
			for (int i = 0; i < 3; i++) begin
				if (par_wr &&
				    par_addr == fieldbus_io_pkg::ADDR_PW8_READ + 16'(i))
					read_map[i] <= par_wdata;
			end
			if (par_rd) begin
				case (par_addr)
					fieldbus_io_pkg::ADDR_PW8_READ:  par_rdata <= read_map[0];
					fieldbus_io_pkg::ADDR_PW9_READ:  par_rdata <= read_map[1];
					fieldbus_io_pkg::ADDR_PW10_READ: par_rdata <= read_map[2];
					default:                         par_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Slot address, enable and returned word
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			slot_addr    <= 48'h0;
			slot_enabled <= 3'h0;
			slot_word    <= 48'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				slot_addr[16*i +: 16] <= read_map[i];
				slot_enabled[i] <=
					read_map[i] > fieldbus_io_pkg::SLOT_DIS_MAX;
				slot_word[16*i +: 16] <=
					(read_map[i] > fieldbus_io_pkg::SLOT_DIS_MAX)
					? slot_data[16*i +: 16] : 16'h0000;
			end
		end
	end

	// Configuration caught once after reset release
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_loaded       <= 1'b0;
			cfg_node         <= 7'h00;
			cfg_fmt          <= fieldbus_io_pkg::FMT_PPO;
			node_err         <= 1'b0;
			cfg_conventional <= 1'b0;
		end else begin
			if (!cfg_loaded) begin
				cfg_loaded <= 1'b1;
				cfg_node   <= node_address_setting;
				cfg_fmt    <= data_format_select;
			end
			node_err <= cfg_loaded && (cfg_node == 7'h00 ||
				cfg_node > fieldbus_io_pkg::NODE_ADDR_MAX);
			cfg_conventional <= cfg_loaded &&
				(cfg_fmt == fieldbus_io_pkg::FMT_CONV ||
				 cfg_fmt == fieldbus_io_pkg::FMT_CONV_ENTER);
		end
	end

	// Enter is issued by the device for Enter-variant writes
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			auto_enter <= 1'b0;
		else
			auto_enter <= fmt_param_wr &&
				(fmt_param_val == fieldbus_io_pkg::FMT_PPO_ENTER ||
				 fmt_param_val == fieldbus_io_pkg::FMT_CONV_ENTER ||
				 fmt_param_val == fieldbus_io_pkg::FMT_BIT0_ENTER);
	end

	assign cur_idx = rx_sof ? 5'h00 : idx;
	assign cur_len = rx_sof ? len_of(frame_len_sel) : len_of(act_len);
	assign take    = rx_valid && !(idx_over && !rx_sof) &&
		{1'b0, cur_idx} < cur_len;

	// Byte position within the frame
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			idx      <= 5'h00;
			idx_over <= 1'b0;
			act_len  <= fieldbus_io_pkg::FRAME_BASIC;
		end else if (rx_valid) begin
			if (rx_sof)
				act_len <= frame_len_sel;
			idx      <= cur_idx + 5'h01;
			idx_over <= (rx_sof ? 1'b0 : idx_over) || cur_idx == 5'h1F;
		end
	end

	// High-speed field assembly, high byte first
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			op_sh       <= 16'h0000;
			freq_sh     <= 16'h0000;
			torque_sh   <= 16'h0000;
			commit_pend <= 1'b0;
		end else begin
			commit_pend <= take && cfg_conventional &&
				cur_idx == hs_last(rx_sof ? frame_len_sel : act_len);
			if (take) begin
				case (cur_idx)
					5'h00: op_sh[15:8]     <= rx_byte;
					5'h01: op_sh[7:0]      <= rx_byte;
					5'h02: freq_sh[15:8]   <= rx_byte;
					5'h03: freq_sh[7:0]    <= rx_byte;
					5'h04: torque_sh[15:8] <= rx_byte;
					5'h05: torque_sh[7:0]  <= rx_byte;
					default: ;
				endcase
			end
		end
	end

	// Commands to the drive, gated by source selection and torque enable
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			drive_cmd <= '0;
		end else if (clear_cmd) begin
			if (!clear_mode_action)
				drive_cmd <= '0;
		end else if (commit_pend) begin
			if (run_cmd_source == fieldbus_io_pkg::SRC_FIELDBUS)
				drive_cmd.op_cmd <= op_sh;
			if (freq_ref_source == fieldbus_io_pkg::SRC_FIELDBUS)
				drive_cmd.freq_ref <= freq_sh;
			if (torque_ref_enable && act_len != fieldbus_io_pkg::FRAME_EXT2)
				drive_cmd.torque_ref <= torque_sh;
		end
	end

	// Message region forwarded to the message editor
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mb_valid <= 1'b0;
			mb_index <= 5'h00;
			mb_byte  <= 8'h00;
		end else begin
			mb_valid <= 1'b0;
			if (take && cfg_conventional) begin
				if ((rx_sof ? frame_len_sel : act_len) ==
				    fieldbus_io_pkg::FRAME_EXT1 &&
				    cur_idx >= fieldbus_io_pkg::MB_BASE_EXT1) begin
					mb_valid <= 1'b1;
					mb_index <= cur_idx - fieldbus_io_pkg::MB_BASE_EXT1;
					mb_byte  <= rx_byte;
				end else if ((rx_sof ? frame_len_sel : act_len) ==
				    fieldbus_io_pkg::FRAME_EXT2 &&
				    cur_idx >= fieldbus_io_pkg::MB_BASE_EXT2) begin
					mb_valid <= 1'b1;
					mb_index <= cur_idx - fieldbus_io_pkg::MB_BASE_EXT2;
					mb_byte  <= rx_byte;
				end
			end
		end
	end

	// Speed field source and message offset of the input frame
	always_comb begin
		spd    = (vf_control || open_loop_pm_control)
			? drive_stat.out_freq : drive_stat.speed;
		mb_off = (act_len == fieldbus_io_pkg::FRAME_EXT1)
			? fieldbus_io_pkg::MB_BASE_EXT1
			: fieldbus_io_pkg::MB_BASE_EXT2;
	end

	// Input frame bytes toward the master
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_ack  <= 1'b0;
			tx_byte <= 8'h00;
		end else begin
			tx_ack  <= tx_req;
			tx_byte <= 8'h00;
			if (tx_req && cfg_conventional &&
			    {1'b0, tx_index} < len_of(act_len)) begin
				if (tx_index < 5'h02)
					tx_byte <= word_byte(drive_stat.status, tx_index[0]);
				else if (tx_index < 5'h04)
					tx_byte <= word_byte(spd, tx_index[0]);
				else if (act_len == fieldbus_io_pkg::FRAME_BASIC)
					tx_byte <= word_byte(drive_stat.current, tx_index[0]);
				else if (tx_index >= mb_off)
					tx_byte <= mb_reply[8*(tx_index - mb_off) +: 8];
			end
		end
	end

	sequence s_last_hs;
		take && cfg_conventional &&
		cur_idx == hs_last(rx_sof ? frame_len_sel : act_len) && !clear_cmd;
	endsequence

	sequence s_commit_run;
		##1 !clear_cmd && run_cmd_source == fieldbus_io_pkg::SRC_FIELDBUS;
	endsequence

	a_slot_disable: assert property (@(posedge mclk) disable iff (!arst_n)
		read_map[0] <= fieldbus_io_pkg::SLOT_DIS_MAX ##1 $stable(read_map[0])
		|-> !slot_enabled[0] && slot_word[15:0] == 16'h0000)
		else $error("disabled read slot not zero");

	a_node_err_flag: assert property (@(posedge mclk) disable iff (!arst_n)
		cfg_loaded && (cfg_node == 7'h00 || cfg_node > 7'h7D) |=> node_err)
		else $error("node address error not flagged");

	a_cfg_held: assert property (@(posedge mclk) disable iff (!arst_n)
		cfg_loaded |=> $stable(cfg_fmt) && $stable(cfg_node))
		else $error("configuration changed after latch");

	a_auto_enter: assert property (@(posedge mclk) disable iff (!arst_n)
		fmt_param_wr && fmt_param_val >= 3'h3 && fmt_param_val <= 3'h5
		|=> auto_enter)
		else $error("enter not issued");

	a_run_forward: assert property (@(posedge mclk) disable iff (!arst_n)
		s_last_hs ##0 s_commit_run |=> drive_cmd.op_cmd == $past(op_sh))
		else $error("run command not forwarded in time");

	a_run_source: assert property (@(posedge mclk) disable iff (!arst_n)
		run_cmd_source != fieldbus_io_pkg::SRC_FIELDBUS && !clear_cmd
		|=> $stable(drive_cmd.op_cmd))
		else $error("run command taken from wrong source");

	a_torque_gate: assert property (@(posedge mclk) disable iff (!arst_n)
		!torque_ref_enable && !clear_cmd |=> $stable(drive_cmd.torque_ref))
		else $error("torque field applied while disabled");

	a_clear_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		clear_cmd && !clear_mode_action |=> drive_cmd == '0)
		else $error("clear mode did not zero outputs");

	a_beyond_len: assert property (@(posedge mclk) disable iff (!arst_n)
		rx_valid && !rx_sof && {1'b0, idx} >= len_of(act_len) |=> !mb_valid)
		else $error("byte beyond frame length used");

endmodule

// *** dv/fieldbus_master_model.sv ***
// Fieldbus master model: sends output frames byte by byte to the mapper.
// Assumes the mapper samples rx_* on the rising edge of mclk.
`timescale 1ns/10ps

module fieldbus_master_model (
	input  wire logic                   mclk,
	output fieldbus_io_pkg::frame_len_t frame_len_sel,
	output logic                        rx_valid,
	output logic                        rx_sof,
	output logic [7:0]                  rx_byte
);
	initial begin
		frame_len_sel = fieldbus_io_pkg::FRAME_BASIC;
		rx_valid      = 1'b0;
		rx_sof        = 1'b0;
		rx_byte       = 8'h00;
	end

	// Gap puts idle cycles between bytes for a slow master
	task automatic send_frame(
		input fieldbus_io_pkg::frame_len_t len,
		input logic [255:0]                f,
		input int                          n,
		input int                          gap
	);
		for (int k = 0; k < n; k++) begin
			@(negedge mclk);
			frame_len_sel = len;
			rx_sof        = (k == 0);
			rx_valid      = 1'b1;
			rx_byte       = f[8*k +: 8];
			repeat (gap) begin
				@(negedge mclk);
				rx_valid = 1'b0;
				rx_sof   = 1'b0;
				rx_byte  = ~rx_byte;
			end
		end
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_sof   = 1'b0;
		// Released line shows no stale byte
		rx_byte  = ~rx_byte;
	endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench of the fieldbus I/O data mapper.
// Assumes the master model drives the frame port; inputs change at negedge.
`timescale 1ns/10ps

`define CHK(g, e) chk(((g) === (e)), 64'(g), 64'(e))

module testbench;
	logic                        mclk = 1'b0;
	logic                        arst_n = 1'b0;
	logic [6:0]                  node_address_setting = 7'h05;
	logic [2:0]                  data_format_select = 3'h1;
	logic                        clear_mode_action = 1'b1;
	logic                        torque_ref_enable = 1'b0;
	logic [1:0]                  run_cmd_source = 2'h2;
	logic [1:0]                  freq_ref_source = 2'h3;
	logic                        vf_control = 1'b0;
	logic                        open_loop_pm_control = 1'b0;
	logic                        fmt_param_wr = 1'b0;
	logic [2:0]                  fmt_param_val = 3'h0;
	logic                        par_wr = 1'b0;
	logic                        par_rd = 1'b0;
	logic [15:0]                 par_addr = 16'h0000;
	logic [15:0]                 par_wdata = 16'h0000;
	logic [47:0]                 slot_data = 48'hC3C3_B2B2_A1A1;
	logic                        clear_cmd = 1'b0;
	logic                        tx_req = 1'b0;
	logic [4:0]                  tx_index = 5'h00;
	fieldbus_io_pkg::drive_stat_t drive_stat = 64'h1122_3344_5566_7788;
	logic [127:0]                mb_reply;
	fieldbus_io_pkg::frame_len_t frame_len_sel;
	logic                        rx_valid, rx_sof, par_ack, node_err;
	logic                        cfg_conventional, auto_enter, mb_valid;
	logic                        tx_ack;
	logic [7:0]                  rx_byte, mb_byte, tx_byte;
	logic [15:0]                 par_rdata, rd;
	logic [47:0]                 slot_addr, slot_word;
	logic [2:0]                  slot_enabled;
	fieldbus_io_pkg::drive_cmd_t drive_cmd;
	logic [4:0]                  mb_index;
	logic [12:0]                 mbq [$];
	logic [7:0]                  bx [7] = '{8'h11, 8'h22, 8'h33, 8'h44,
		8'h77, 8'h88, 8'h00};
	logic [6:0]                  nodes [6] = '{7'h00, 7'h01, 7'h7D,
		7'h7E, 7'h7F, 7'h40};
	int                          bad_count = 0;
	int                          checks_done = 0;

	always #2 mclk = ~mclk;

	initial begin
		for (int k = 0; k < 16; k++) begin
			mb_reply[8*k +: 8] = 8'hA0 + 8'(k);
		end
	end

	fieldbus_master_model master (.mclk(mclk), .frame_len_sel(frame_len_sel),
		.rx_valid(rx_valid), .rx_sof(rx_sof), .rx_byte(rx_byte));

	fieldbus_io_data_mapper #(.MB_BYTES(16)) dut (.mclk(mclk),
		.arst_n(arst_n), .node_address_setting(node_address_setting),
		.data_format_select(data_format_select),
		.clear_mode_action(clear_mode_action),
		.torque_ref_enable(torque_ref_enable),
		.run_cmd_source(run_cmd_source), .freq_ref_source(freq_ref_source),
		.vf_control(vf_control),
		.open_loop_pm_control(open_loop_pm_control),
		.fmt_param_wr(fmt_param_wr), .fmt_param_val(fmt_param_val),
		.par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr),
		.par_wdata(par_wdata), .slot_data(slot_data),
		.frame_len_sel(frame_len_sel), .rx_valid(rx_valid),
		.rx_sof(rx_sof), .rx_byte(rx_byte), .clear_cmd(clear_cmd),
		.tx_req(tx_req), .tx_index(tx_index), .drive_stat(drive_stat),
		.mb_reply(mb_reply), .par_rdata(par_rdata), .par_ack(par_ack),
		.slot_addr(slot_addr), .slot_enabled(slot_enabled),
		.slot_word(slot_word), .node_err(node_err),
		.cfg_conventional(cfg_conventional), .auto_enter(auto_enter),
		.drive_cmd(drive_cmd), .mb_valid(mb_valid), .mb_index(mb_index),
		.mb_byte(mb_byte), .tx_ack(tx_ack), .tx_byte(tx_byte));

	always @(negedge mclk) begin
		if (mb_valid === 1'b1) begin
			mbq.push_back({mb_index, mb_byte});
		end
	end

	task automatic chk(input logic ok, input logic [63:0] g,
		input logic [63:0] e);
		checks_done++;
		if (!ok) begin
			bad_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask

	task automatic wrap_up();
		if (bad_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic do_reset(input logic [6:0] n, input logic [2:0] f);
		arst_n               = 1'b0;
		node_address_setting = n;
		data_format_select   = f;
		repeat (16) @(negedge mclk);
		arst_n = 1'b1;
		repeat (4) @(negedge mclk);
	endtask

	task automatic par(input logic wr, input logic [15:0] a,
		input logic [15:0] d);
		@(negedge mclk);
		par_wr    = wr;
		par_rd    = ~wr;
		par_addr  = a;
		par_wdata = d;
		@(negedge mclk);
		par_wr = 1'b0;
		par_rd = 1'b0;
		`CHK(par_ack, 1'b1);
		rd = par_rdata;
	endtask

	task automatic tx(input logic [4:0] i, input logic [7:0] e);
		@(negedge mclk);
		tx_req   = 1'b1;
		tx_index = i;
		@(negedge mclk);
		tx_req = 1'b0;
		`CHK(tx_ack, 1'b1);
		`CHK(tx_byte, e);
	endtask

	task automatic chk_mb(input int cnt, input logic [7:0] base);
		`CHK(mbq.size(), cnt);
		for (int k = 0; k < mbq.size(); k++) begin
			`CHK(mbq[k], {5'(k), base + 8'(k)});
		end
		mbq.delete();
	endtask

	function automatic logic [255:0] fr(input logic [7:0] b);
		logic [255:0] f;
		for (int k = 0; k < 32; k++) begin
			f[8*k +: 8] = b + 8'(k);
		end
		return f;
	endfunction

	initial begin
		#20000;
		bad_count++;
		wrap_up();
	end

	initial begin
		for (int i = 0; i < 6; i++) begin
			do_reset(nodes[i], 3'(i));
			`CHK(node_err, (i == 0 || i == 3 || i == 4));
			`CHK(cfg_conventional, (i == 1 || i == 4));
			node_address_setting = 7'h05 - 7'(i);
			data_format_select   = (i == 1) ? 3'h0 : 3'h1;
			repeat (3) @(negedge mclk);
			`CHK(node_err, (i == 0 || i == 3 || i == 4));
			`CHK(cfg_conventional, (i == 1 || i == 4));
			if (i != 1 && i != 4) begin
				// Command word 1011 carries control bits 0, 4 and 12 together
				master.send_frame(fieldbus_io_pkg::FRAME_BASIC,
					fr(8'h10), 6, 0);
				@(negedge mclk);
				`CHK(drive_cmd, 48'h0);
				tx(5'h00, 8'h00);
			end
		end
		do_reset(7'h05, fieldbus_io_pkg::FMT_CONV_ENTER);
		for (int a = 0; a < 4; a++) begin
			par(1'b0, 16'h0791 + 16'(a), 16'h0000);
			`CHK(rd, 16'h0000);
		end
		par(1'b1, 16'h0791, 16'h1234);
		par(1'b1, 16'h0792, 16'h0002);
		par(1'b1, 16'h0793, 16'h0003);
		par(1'b1, 16'h0794, 16'hFFFF);
		@(negedge mclk);
		`CHK(slot_enabled, 3'h5);
		`CHK(slot_addr, 48'h0003_0002_1234);
		`CHK(slot_word, 48'hC3C3_0000_A1A1);
		par(1'b0, 16'h0792, 16'h0000);
		`CHK(rd, 16'h0002);
		par(1'b0, 16'h0794, 16'h0000);
		`CHK(rd, 16'h0000);
		for (int v = 0; v < 6; v++) begin
			@(negedge mclk);
			fmt_param_wr  = 1'b1;
			fmt_param_val = 3'(v);
			@(negedge mclk);
			fmt_param_wr = 1'b0;
			`CHK(auto_enter, (v >= 3));
		end
		`CHK(cfg_conventional, 1'b1);
		master.send_frame(fieldbus_io_pkg::FRAME_BASIC, fr(8'h10), 8, 0);
		@(negedge mclk);
		`CHK(drive_cmd, 48'h0000_1213_0000);
		chk_mb(0, 8'h00);
		run_cmd_source    = 2'h3;
		torque_ref_enable = 1'b1;
		master.send_frame(fieldbus_io_pkg::FRAME_BASIC, fr(8'h40), 6, 0);
		@(negedge mclk);
		`CHK(drive_cmd, 48'h4041_4243_4445);
		for (int k = 0; k < 7; k++) begin
			tx(5'(k), bx[k]);
		end
		vf_control = 1'b1;
		tx(5'h02, 8'h55);
		vf_control           = 1'b0;
		open_loop_pm_control = 1'b1;
		tx(5'h03, 8'h66);
		open_loop_pm_control = 1'b0;
		freq_ref_source = 2'h0;
		master.send_frame(fieldbus_io_pkg::FRAME_EXT2, fr(8'h60), 12, 1);
		@(negedge mclk);
		`CHK(drive_cmd, 48'h6061_4243_4445);
		freq_ref_source = 2'h3;
		chk_mb(8, 8'h64);
		tx(5'h04, 8'hA0);
		tx(5'h0B, 8'hA7);
		tx(5'h0C, 8'h00);
		master.send_frame(fieldbus_io_pkg::FRAME_EXT1, fr(8'h80), 32, 0);
		@(negedge mclk);
		`CHK(drive_cmd, 48'h8081_8283_8485);
		chk_mb(16, 8'h90);
		tx(5'h10, 8'hA0);
		tx(5'h1F, 8'hAF);
		tx(5'h05, 8'h00);
		for (int m = 1; m >= 0; m--) begin
			clear_mode_action = 1'(m);
			@(negedge mclk);
			clear_cmd = 1'b1;
			@(negedge mclk);
			clear_cmd = 1'b0;
			`CHK(drive_cmd, (m == 1) ? 48'h8081_8283_8485 : 48'h0);
		end
		wrap_up();
	end
endmodule
